// File: hw/eio_port.sv
// External control and status port with AHB-Lite register access
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module eio_port #(
   parameter int unsigned PER_MIN = eio_pkg::PER_MIN_CYC,
   parameter int unsigned PER_MAX = eio_pkg::PER_MAX_CYC
) (
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   input  wire eio_pkg::eio_src_t       src,
   input  wire logic [6:0]              cmd_pin_n,
   input  wire logic                    sync_signal_pin,
   input  wire logic                    sync_line_pin,
   input  wire eio_pkg::eio_smp_t [2:0] ext_in,
   input  wire eio_pkg::eio_smp_t [2:0] wave_in,
   input  wire eio_pkg::eio_smp_t [2:0] v_meas,
   input  wire eio_pkg::eio_smp_t [2:0] i_meas,
   output eio_pkg::eio_pin_t            stat_pin,
   output eio_pkg::eio_cmd_t            cmd_pulse,
   output eio_pkg::eio_smp_t [2:0]      drive_out,
   output eio_pkg::eio_smp_t [1:0]      mon_out,
   output eio_pkg::eio_mode_t           mode_out,
   output logic [eio_pkg::PER_W-1:0]    lock_period,
   output logic                         lock_ok,
   output logic                         out_inhibit
);
   import eio_pkg::*;

   localparam logic [PER_W-1:0] PMIN = PER_W'(PER_MIN);
   localparam logic [PER_W-1:0] PMAX = PER_W'(PER_MAX);
   localparam logic [PER_W-1:0] PONE = PER_W'(1);

   eio_bus_t          bus_st_q;
   logic [ADDR_W-1:0] addr_q;
   logic              wr_q;
   logic              ok_q;
   logic [31:0]       hrdata_q;
   logic              hreadyout_q;
   logic              hresp_q;
   eio_mode_t         mode_q;
   logic              range_hi_q;
   logic              sync_line_q;
   logic [2:0]        par_n_q;
   logic [GAIN_W-1:0] gain_lo_q;
   logic [GAIN_W-1:0] gain_hi_q;
   eio_mon_t [1:0]    mon_q;
   logic [23:0]       cscale_q;
   logic [6:0]        cmd_s1_q;
   logic [6:0]        cmd_s2_q;
   logic [6:0]        cmd_prev_q;
   logic [6:0]        cmd_seen_q;
   logic [6:0]        cmd_seen_d;
   eio_cmd_t          cmd_pulse_q;
   logic [1:0]        sync_s1_q;
   logic [1:0]        sync_s2_q;
   logic              sync_prev_q;
   logic [PER_W-1:0]  per_cnt_q;
   logic [PER_W-1:0]  period_q;
   logic              lock_ok_q;
   logic              overfreq_q;
   logic              inhibit_q;
   eio_pin_t          pin_q;
   eio_smp_t [2:0]    drive_q;
   eio_smp_t [1:0]    mon_res_q;

   // Bus decode
   wire logic        take    = hsel & htrans[1] & hready;
   wire logic        exec    = (bus_st_q == BUS_EXEC);
   wire logic        wr_ok   = exec & wr_q & ok_q;
   wire logic        wr_ctrl = wr_ok & (addr_q == ADDR_CTRL);
   wire logic        wr_glo  = wr_ok & (addr_q == ADDR_GAINLO);
   wire logic        wr_ghi  = wr_ok & (addr_q == ADDR_GAINHI);
   wire logic        wr_mon  = wr_ok & (addr_q == ADDR_MON);
   wire logic        wr_csc  = wr_ok & (addr_q == ADDR_CSCALE);
   wire logic        wr_evt  = wr_ok & (addr_q == ADDR_EVENTS);
   wire logic [12:0] glo_new = (hwdata > 32'(GAIN_MAX_LO)) ? GAIN_MAX_LO : hwdata[12:0];
   wire logic [12:0] ghi_new = (hwdata > 32'(GAIN_MAX_HI)) ? GAIN_MAX_HI : hwdata[12:0];

   wire logic [31:0] rd_ctrl = {21'h000000, par_n_q, 3'h0, sync_line_q, range_hi_q, mode_q};
   wire logic [31:0] rd_stat = {18'h00000, inhibit_q, overfreq_q, lock_ok_q, src};
   wire logic [31:0] rd_mux  =
      !ok_q                     ? 32'h00000000 :
      (addr_q == ADDR_CTRL)     ? rd_ctrl :
      (addr_q == ADDR_GAINLO)   ? {19'h00000, gain_lo_q} :
      (addr_q == ADDR_GAINHI)   ? {19'h00000, gain_hi_q} :
      (addr_q == ADDR_MON)      ? {24'h000000, mon_q} :
      (addr_q == ADDR_CSCALE)   ? {8'h00, cscale_q} :
      (addr_q == ADDR_STATUS)   ? rd_stat :
      (addr_q == ADDR_PERIOD)   ? {11'h000, period_q} :
      (addr_q == ADDR_EVENTS)   ? {25'h0000000, cmd_seen_q} : 32'h00000000;

   // One wait state per transfer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_q    <= BUS_IDLE;
         addr_q      <= 8'h00;
         wr_q        <= 1'b0;
         ok_q        <= 1'b0;
         hrdata_q    <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         hresp_q <= 1'b0;
         unique case (bus_st_q)
            BUS_IDLE: begin
               if (take) begin
                  bus_st_q    <= BUS_EXEC;
                  addr_q      <= haddr[ADDR_W-1:0];
                  wr_q        <= hwrite;
                  ok_q        <= (haddr[31:ADDR_W] == 24'h000000) && (hsize == HSIZE_WORD);
                  hreadyout_q <= 1'b0;
               end
            end
            BUS_EXEC: begin
               bus_st_q    <= BUS_IDLE;
               hrdata_q    <= wr_q ? 32'h00000000 : rd_mux;
               hreadyout_q <= 1'b1;
            end
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q      <= INTERNAL_MODE;
         range_hi_q  <= 1'b0;
         sync_line_q <= 1'b0;
         par_n_q     <= PAR_RST;
         gain_lo_q   <= GAIN_RST_LO;
         gain_hi_q   <= GAIN_RST_HI;
         mon_q       <= {MON_RST};
         cscale_q    <= CSCALE_RST;
      end else begin
         if (wr_ctrl) begin
            mode_q      <= eio_mode_t'(hwdata[2:0]);
            range_hi_q  <= hwdata[3];
            sync_line_q <= hwdata[4];
            par_n_q     <= (hwdata[10:8] == 3'h0) ? PAR_ONE : hwdata[10:8];
         end
         if (wr_glo) begin
            gain_lo_q <= glo_new;
         end
         if (wr_ghi) begin
            gain_hi_q <= ghi_new;
         end
         if (wr_mon) begin
            mon_q <= hwdata[7:0];
         end
         if (wr_csc) begin
            cscale_q <= hwdata[23:0];
         end
      end
   end

   // Command pins: synchronise, then falling edge
   wire logic [6:0] cmd_fall = cmd_prev_q & ~cmd_s2_q;
   assign cmd_seen_d = (cmd_seen_q & ~({7{wr_evt}} & hwdata[6:0])) | cmd_fall;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_s1_q    <= CMD_IDLE;
         cmd_s2_q    <= CMD_IDLE;
         cmd_prev_q  <= CMD_IDLE;
         cmd_seen_q  <= 7'h00;
         cmd_pulse_q <= '0;
      end else begin
         cmd_s1_q    <= cmd_pin_n;
         cmd_s2_q    <= cmd_s1_q;
         cmd_prev_q  <= cmd_s2_q;
         cmd_seen_q  <= cmd_seen_d;
         cmd_pulse_q <= cmd_fall;
      end
   end

   // Sync period measurement
   wire logic sync_sel  = sync_line_q ? sync_s2_q[1] : sync_s2_q[0];
   wire logic sync_rise = sync_sel & ~sync_prev_q;
   wire logic in_band   = (per_cnt_q >= PMIN) && (per_cnt_q <= PMAX);
   wire logic is_lock   = (mode_q == FREQ_LOCK_ACDC_MODE) || (mode_q == FREQ_LOCK_AC_MODE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_s1_q   <= 2'b00;
         sync_s2_q   <= 2'b00;
         sync_prev_q <= 1'b0;
         per_cnt_q   <= '0;
         period_q    <= '0;
         lock_ok_q   <= 1'b0;
         overfreq_q  <= 1'b0;
         inhibit_q   <= 1'b0;
      end else begin
         sync_s1_q   <= {sync_line_pin, sync_signal_pin};
         sync_s2_q   <= sync_s1_q;
         sync_prev_q <= sync_sel;
         if (sync_rise) begin
            per_cnt_q  <= PONE;
            lock_ok_q  <= in_band;
            overfreq_q <= (per_cnt_q < PMIN);
            if (in_band) begin
               period_q <= per_cnt_q;
            end
         end else if (per_cnt_q <= PMAX) begin
            per_cnt_q <= per_cnt_q + PONE;
         end else begin
            lock_ok_q <= 1'b0;
         end
         inhibit_q <= is_lock & overfreq_q;
      end
   end

   // Status pins
   wire logic limit_any = src.lim_pos_peak | src.lim_neg_peak | src.lim_avg | src.lim_power;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q <= '0;
      end else begin
         pin_q.power_on  <= src.power_on;
         pin_q.output_on <= src.output_on;
         pin_q.busy      <= src.busy;
         pin_q.limit     <= limit_any;
         pin_q.seq_sync  <= src.seq_sync;
         pin_q.trigger   <= src.trigger;
      end
   end

   // Per-phase drive path
   wire logic [GAIN_W-1:0] gain_sel = range_hi_q ? gain_hi_q : gain_lo_q;
   wire logic signed [31:0] lim_sel = range_hi_q ? LIM_HI : LIM_LO;

   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         wire logic signed [15:0] ext_s  = $signed(ext_in[p]);
         wire logic signed [15:0] wave_s = $signed(wave_in[p]);
         wire logic signed [29:0] gprod  = 30'(ext_s * $signed({1'b0, gain_sel}));
         wire logic signed [29:0] gval   = gprod / GAIN_DIV;
         wire logic signed [31:0] sum_v  = 32'(gval) + 32'(wave_s);
         wire logic signed [15:0] ctl    = (ext_s > VCA_FS)  ? VCA_FS :
                                           (ext_s < -VCA_FS) ? -VCA_FS : ext_s;
         wire logic signed [31:0] vprod  = 32'(wave_s * ctl) >>> VCA_SHIFT;
         wire logic signed [31:0] vclip  = (vprod > lim_sel)  ? lim_sel :
                                           (vprod < -lim_sel) ? -lim_sel : vprod;
         wire logic signed [31:0] pick   =
            ((mode_q == EXT_GAIN_ACDC_MODE) || (mode_q == EXT_GAIN_AC_MODE)) ? 32'(gval) :
            ((mode_q == EXT_SUM_ACDC_MODE)  || (mode_q == EXT_SUM_AC_MODE))  ? sum_v :
            (mode_q == DC_AMPLITUDE_CONTROL_MODE) ? vclip : 32'(wave_s);
         wire logic signed [15:0] sat    = (pick > 32'sh00007FFF)  ? 16'sh7FFF :
                                           (pick < -32'sh00008000) ? 16'sh8000 : pick[15:0];

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               drive_q[p] <= '0;
            end else begin
               drive_q[p] <= (inhibit_q | (is_lock & ~lock_ok_q)) ? 16'sh0000 : sat;
            end
         end
      end
   endgenerate

   // Monitor outputs
   genvar m;
   generate
      for (m = 0; m < 2; m++) begin : g_mon
         wire logic [1:0] ph    = (mon_q[m].phase == 2'h3) ? 2'h0 : mon_q[m].phase;
         wire eio_smp_t   smp   = mon_q[m].current ? i_meas[ph] : v_meas[ph];
         wire logic [3:0] c_num = mon_q[m].level_high ? cscale_q[3:0] : cscale_q[15:12];
         wire logic [7:0] c_den = mon_q[m].level_high ? cscale_q[11:4] : cscale_q[23:16];
         wire logic [3:0] v_num = mon_q[m].level_high ? VNUM_H : VNUM_L;
         wire logic [7:0] v_den = range_hi_q ? VDEN_HI : VDEN_LO;
         wire eio_smp_t   res;

         eio_mon_scale u_scale (
            .smp    (smp),
            .num    (mon_q[m].current ? c_num : v_num),
            .den    (mon_q[m].current ? c_den : v_den),
            .par_n  (mon_q[m].current ? par_n_q : PAR_ONE),
            .scaled (res)
         );

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               mon_res_q[m] <= '0;
            end else begin
               mon_res_q[m] <= res;
            end
         end
      end
   endgenerate

   assign hrdata      = hrdata_q;
   assign hreadyout   = hreadyout_q;
   assign hresp       = hresp_q;
   assign stat_pin    = pin_q;
   assign cmd_pulse   = cmd_pulse_q;
   assign drive_out   = drive_q;
   assign mon_out     = mon_res_q;
   assign mode_out    = mode_q;
   assign lock_period = period_q;
   assign lock_ok     = lock_ok_q;
   assign out_inhibit = inhibit_q;

   // Checks
   power_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      src.power_on |=> stat_pin.power_on) else $error("power pin missed source on");
   output_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !src.output_on |=> !stat_pin.output_on) else $error("output pin high while off");
   busy_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
      stat_pin.busy == $past(src.busy)) else $error("busy pin wrong");
   limiter_any_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (src.lim_pos_peak || src.lim_neg_peak || src.lim_avg || src.lim_power) |=> stat_pin.limit)
      else $error("limit pin low");
   seq_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 stat_pin.seq_sync == $past(src.seq_sync)) else $error("seq sync mismatch");
   cmd_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (cmd_pulse != 7'h00) |-> (cmd_pulse == ($past(cmd_pin_n, 4) & ~$past(cmd_pin_n, 3))))
      else $error("command pulse without falling edge");
   cmd_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_pulse.out_on |=> !cmd_pulse.out_on) else $error("command pulse too long");
   gain_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gain_lo_q <= GAIN_MAX_LO) && (gain_hi_q <= GAIN_MAX_HI)) else $error("gain over limit");
   overfreq_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (is_lock && overfreq_q) |=> out_inhibit ##1 (drive_out == '0))
      else $error("overfrequency did not disable output");
   bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (take && bus_st_q == BUS_IDLE) |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
endmodule

// File: hw/eio_pkg.sv
// Constants, types and register map of the external control port
package eio_pkg;
   localparam int unsigned CLK_HZ      = 20_000_000;
   localparam int unsigned SYNC_MAX_HZ = 2000;
   localparam int unsigned SYNC_MIN_HZ = 15;
   localparam int unsigned PER_MIN_CYC = CLK_HZ / SYNC_MAX_HZ;
   localparam int unsigned PER_MAX_CYC = CLK_HZ / SYNC_MIN_HZ;
   localparam int          PER_W       = 21;

   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_GAINLO = 8'h04;
   localparam logic [7:0]  ADDR_GAINHI = 8'h08;
   localparam logic [7:0]  ADDR_MON    = 8'h0C;
   localparam logic [7:0]  ADDR_CSCALE = 8'h10;
   localparam logic [7:0]  ADDR_STATUS = 8'h14;
   localparam logic [7:0]  ADDR_PERIOD = 8'h18;
   localparam logic [7:0]  ADDR_EVENTS = 8'h1C;
   localparam logic [2:0]  HSIZE_WORD  = 3'h2;

   // Gain in tenths
   localparam int          GAIN_W      = 13;
   localparam logic [12:0] GAIN_MAX_LO = 13'h09C4;
   localparam logic [12:0] GAIN_MAX_HI = 13'h1388;
   localparam logic [12:0] GAIN_RST_LO = 13'h03E8;
   localparam logic [12:0] GAIN_RST_HI = 13'h07D0;
   localparam logic signed [29:0] GAIN_DIV = 30'sh0000000A;

   // Sample codes: full scale of an input sample is 10 V
   localparam logic signed [15:0] VCA_FS    = 16'sh2000;
   localparam int                 VCA_SHIFT = 13;
   localparam logic signed [31:0] LIM_LO    = 32'sh00003000;
   localparam logic signed [31:0] LIM_HI    = 32'sh00006000;

   localparam logic [3:0]  VNUM_H      = 4'h4;
   localparam logic [3:0]  VNUM_L      = 4'h1;
   localparam logic [7:0]  VDEN_LO     = 8'h7D;
   localparam logic [7:0]  VDEN_HI     = 8'hFA;
   localparam logic [2:0]  PAR_ONE     = 3'h1;
   localparam logic [23:0] CSCALE_RST  = 24'h280A1A;
   localparam logic [7:0]  MON_RST     = 8'h00;
   localparam logic [2:0]  PAR_RST     = 3'h1;
   localparam logic [6:0]  CMD_IDLE    = 7'h7F;

   typedef logic signed [15:0] eio_smp_t;

   typedef enum logic [2:0] {
      INTERNAL_MODE             = 3'h0,
      EXT_GAIN_ACDC_MODE        = 3'h1,
      EXT_GAIN_AC_MODE          = 3'h2,
      EXT_SUM_ACDC_MODE         = 3'h3,
      EXT_SUM_AC_MODE           = 3'h4,
      FREQ_LOCK_ACDC_MODE       = 3'h5,
      FREQ_LOCK_AC_MODE         = 3'h6,
      DC_AMPLITUDE_CONTROL_MODE = 3'h7
   } eio_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_EXEC = 2'b10
   } eio_bus_t;

   typedef struct packed {
      logic       trigger;
      logic [2:0] seq_sync;
      logic       lim_power;
      logic       lim_avg;
      logic       lim_neg_peak;
      logic       lim_pos_peak;
      logic       busy;
      logic       output_on;
      logic       power_on;
   } eio_src_t;

   typedef struct packed {
      logic       trigger;
      logic [2:0] seq_sync;
      logic       busy;
      logic       limit;
      logic       output_on;
      logic       power_on;
   } eio_pin_t;

   typedef struct packed {
      logic branch2;
      logic branch1;
      logic seq_hold;
      logic seq_stop;
      logic seq_start;
      logic out_on;
      logic out_off;
   } eio_cmd_t;

   typedef struct packed {
      logic       level_high;
      logic       current;
      logic [1:0] phase;
   } eio_mon_t;
endpackage

// File: hw/eio_mon_scale.sv
// Monitor scaling: sample times num over den times parallel count
`timescale 1ns/10ps
module eio_mon_scale (
   input  wire eio_pkg::eio_smp_t smp,
   input  wire logic [3:0]        num,
   input  wire logic [7:0]        den,
   input  wire logic [2:0]        par_n,
   output eio_pkg::eio_smp_t      scaled
);
   import eio_pkg::*;

   wire logic signed [20:0] prod;
   wire logic [10:0]        div_raw;
   wire logic [10:0]        div_safe;
   wire logic signed [20:0] quot;

   assign prod     = 21'(smp * $signed({1'b0, num}));
   assign div_raw  = 11'(den * par_n);
   // Guard against a zero divisor from bad settings
   assign div_safe = (div_raw == 11'h000) ? 11'h001 : div_raw;
   assign quot     = prod / $signed({10'h000, div_safe});
   assign scaled   = (quot > 21'sh07FFF)  ? 16'sh7FFF :
                     (quot < -21'sh08000) ? 16'sh8000 : quot[15:0];
endmodule

// File: verification/eio_ctl_model.sv
// Behavioural model of the outside controller on command and sync lines
`timescale 1ns/10ps
module eio_ctl_model (
   input  wire logic        hclk,
   output logic [6:0]       cmd_pin_n,
   output wire logic        sync_signal_pin,
   output wire logic        sync_line_pin
);
   logic [1:0] sp;
   assign sync_signal_pin = sp[0];
   assign sync_line_pin = sp[1];

   initial begin
      cmd_pin_n = 7'h7F;
      sp = 2'b00;
   end

   // Command as one falling edge, held low, then released high
   task automatic fall(input int i);
      cmd_pin_n <= cmd_pin_n & ~(7'h01 << i);
      repeat (4) @(posedge hclk);
      cmd_pin_n <= 7'h7F;
      repeat (4) @(posedge hclk);
   endtask

   // Burst of sync pulses; both lines stand low between bursts
   task automatic sync_run(input logic line, input int per, input int cnt);
      repeat (cnt) begin
         sp <= line ? 2'b10 : 2'b01;
         repeat (per / 2) @(posedge hclk);
         sp <= 2'b00;
         repeat (per - per / 2) @(posedge hclk);
      end
   endtask
endmodule

// File: verification/tb_eio_port.sv
// Self-checking bench of the external control port
`timescale 1ns/10ps
module tb_eio_port;
   import eio_pkg::*;
   logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, lock_ok, out_inhibit;
   logic             sync_signal_pin, sync_line_pin;
   logic [31:0]      haddr, hwdata, hrdata, rv, cs;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [6:0]       cmd_n;
   logic [15:0]      lf, r;
   eio_src_t         src;
   eio_pin_t         stat_pin;
   eio_cmd_t         cmd_pulse;
   eio_mode_t        mode_out;
   eio_smp_t [2:0]   ext_in, wave_in, v_meas, i_meas, drive_out;
   eio_smp_t [1:0]   mon_out;
   logic [PER_W-1:0] lock_period;
   int               error_cnt, cmp_count, n, g, p;
   int               pc [7];

   eio_port #(.PER_MIN(8), .PER_MAX(64)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src(src),
      .cmd_pin_n(cmd_n), .sync_signal_pin(sync_signal_pin), .sync_line_pin(sync_line_pin),
      .ext_in(ext_in), .wave_in(wave_in), .v_meas(v_meas), .i_meas(i_meas),
      .stat_pin(stat_pin), .cmd_pulse(cmd_pulse), .drive_out(drive_out), .mon_out(mon_out),
      .mode_out(mode_out), .lock_period(lock_period), .lock_ok(lock_ok),
      .out_inhibit(out_inhibit));
   eio_ctl_model i_ctl (.hclk(hclk), .cmd_pin_n(cmd_n), .sync_signal_pin(sync_signal_pin),
      .sync_line_pin(sync_line_pin));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   always @(negedge hclk) for (int k = 0; k < 7; k++) pc[k] += int'(cmd_pulse[k]);

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         error_cnt++;
      end
   endtask

   // One single word transfer; waits are bounded
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int k;
      // Requests change only just after a rising edge
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      k = 0;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
      rd = hrdata;
      chk("hresp", hresp, 32'h0);
      if (k >= 100) begin
         $display("BAD bus_wait expected ready seen stuck");
         error_cnt++;
         print_verdict();
      end
   endtask

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction

   function automatic logic [15:0] sat(input longint v);
      if (v > 32767) return 16'h7FFF;
      if (v < -32768) return 16'h8000;
      return v[15:0];
   endfunction

   task automatic settle();
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = HSIZE_WORD;
      {src, ext_in, wave_in, v_meas, i_meas} = '0;
      lf = 16'h6C47;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, ADDR_GAINLO, 32'h0, rv);
      chk("gain_lo_rst", rv, 32'h3E8);
      bus(1'b0, ADDR_GAINHI, 32'h0, rv);
      chk("gain_hi_rst", rv, 32'h7D0);
      bus(1'b1, ADDR_GAINLO, 32'hBB8, rv);
      bus(1'b0, ADDR_GAINLO, 32'h0, rv);
      chk("gain_clamp", rv, 32'h9C4);
      bus(1'b0, 8'h20, 32'h0, rv);
      chk("unmapped", rv, 32'h0);
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         src <= r[10:0];
         @(posedge hclk);
         @(negedge hclk);
         chk("stat_pin", stat_pin, {src.trigger, src.seq_sync, src.busy, src.lim_pos_peak |
            src.lim_neg_peak | src.lim_avg | src.lim_power, src.output_on, src.power_on});
         @(posedge hclk);
      end
      for (int i = 0; i < 7; i++) begin
         n = pc[i];
         i_ctl.fall(i);
         chk("cmd_pulse", pc[i] - n, 32'h1);
      end
      chk("pulse_total", pc.sum(), 32'h7);
      bus(1'b0, ADDR_EVENTS, 32'h0, rv);
      chk("events", rv, 32'h7F);
      bus(1'b1, ADDR_EVENTS, 32'h7F, rv);
      bus(1'b0, ADDR_EVENTS, 32'h0, rv);
      chk("events_clr", rv, 32'h0);
      for (int m = 1; m <= 4; m++) begin
         g = int'(rnd() % 16'h09C5);
         bus(1'b1, ADDR_GAINLO, g, rv);
         bus(1'b1, ADDR_CTRL, m, rv);
         for (int k = 0; k < 3; k++) begin
            r = rnd();
            ext_in[k] <= {{8{r[7]}}, r[7:0]};
            wave_in[k] <= rnd();
         end
         settle();
         chk("mode", mode_out, m);
         for (int k = 0; k < 3; k++)
            chk("drive", drive_out[k][15:0], sat(longint'(ext_in[k]) * g / 10 +
               (m > 2 ? wave_in[k] : 0)));
      end
      for (int h = 0; h < 2; h++) begin
         bus(1'b1, ADDR_CTRL, h ? 32'hF : 32'h7, rv);
         ext_in[0] <= 16'sh2800;
         wave_in[0] <= 16'sh4000;
         p = int'(rnd() % 16'h0003);
         bus(1'b1, ADDR_MON, (p << 4) | 32'h8 | p, rv);
         v_meas[p] <= rnd();
         settle();
         chk("amp_clamp", drive_out[0][15:0], h ? 32'h4000 : 32'h3000);
         chk("mon_hi", mon_out[0][15:0], sat(longint'(v_meas[p]) * 4 / (h ? 250 : 125)));
         chk("mon_lo", mon_out[1][15:0], sat(longint'(v_meas[p]) / (h ? 250 : 125)));
      end
      bus(1'b0, ADDR_CSCALE, 32'h0, cs);
      chk("cscale_rst", cs, 32'(CSCALE_RST));
      for (int k = 1; k < 4; k++) begin
         bus(1'b1, ADDR_CTRL, k << 8, rv);
         bus(1'b1, ADDR_MON, 32'hC, rv);
         i_meas[0] <= rnd();
         settle();
         chk("mon_cur", mon_out[0][15:0], sat(longint'(i_meas[0]) * int'(CSCALE_RST[3:0]) /
            (int'(CSCALE_RST[11:4]) * k)));
      end
      bus(1'b1, ADDR_CTRL, 32'h5, rv);
      wave_in[0] <= 16'sh1234;
      i_ctl.sync_run(1'b0, 20, 4);
      @(negedge hclk);
      chk("lock_ok", lock_ok, 32'h1);
      chk("lock_period", lock_period, 32'd20);
      chk("lock_drive", drive_out[0][15:0], 32'h1234);
      bus(1'b1, ADDR_CTRL, 32'h16, rv);
      i_ctl.sync_run(1'b1, 30, 4);
      @(negedge hclk);
      chk("line_period", lock_period, 32'd30);
      repeat (80) @(posedge hclk);
      @(negedge hclk);
      chk("lock_lost", lock_ok, 32'h0);
      @(posedge hclk);
      i_ctl.sync_run(1'b1, 4, 6);
      @(negedge hclk);
      chk("inhibit", out_inhibit, 32'h1);
      chk("inhibit_drive", drive_out[0][15:0], 32'h0);
      print_verdict();
   end

   initial begin
      repeat (40000) @(posedge hclk);
      $display("BAD run_time expected done seen hang");
      error_cnt++;
      print_verdict();
   end
endmodule
